// >>> logic/phase_timer.sv
// Phase timer: one-cycle tick after a fixed number of clock cycles
// Assumes start is a single-cycle request from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module phase_timer (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic start_in,
	output logic      tick_out
);
	localparam int unsigned W = wiper_host_pkg::CNT_W;
	localparam logic [W-1:0] LOAD = W'(wiper_host_pkg::PHASE_CYC - 1);
	logic [wiper_host_pkg::CNT_W-1:0] cnt_q;
	logic                             run_q;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q    <= '0;
			run_q    <= 1'b0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (start_in) begin
				cnt_q <= LOAD;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q == '0) begin
					run_q    <= 1'b0;
					tick_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end
endmodule // phase_timer
`default_nettype wire

// >>> logic/wiper_host.sv
// Host controller driving select, direction and step pins of a 32-tap pot
// Assumes commands come from logic on ref_clk_in; device recalls at power-up
//
// Function
// - Select low, direction high: falling step moves up
// - Select low, direction low: falling step moves down
// - Select rising with step high stores value
// - Select rising with step low skips store
`timescale 1ns/1ps
`default_nettype none
module wiper_host (
	input  wire logic                 ref_clk_in,
	input  wire logic                 rst_in,
	input  wire logic                 cmd_valid_in,
	input  wire wiper_host_pkg::cmd_t cmd_in,
	input  wire logic [4:0]           recall_pos_in,
	input  wire logic                 recall_load_in,
	output logic                      cmd_ready_out,
	output wiper_host_pkg::pins_t     pins_out,
	output logic [4:0]                live_pos_out,
	output logic [4:0]                stored_pos_out,
	output logic                      done_out
);
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SETUP  = 3'h1,
		ST_FALL   = 3'h2,
		ST_RISE   = 3'h3,
		ST_DESEL  = 3'h4,
		ST_FINISH = 3'h5
	} state_t;

	state_t                  state_q;
	wiper_host_pkg::cmd_t    cmd_q;
	logic [4:0]              left_q;
	logic                    t_start;
	logic                    t_tick;

	function automatic logic [4:0] step_pos(input logic [4:0] p,
		input logic up);
		if (up)
			step_pos = (p == wiper_host_pkg::POS_HIGH) ? p : p + 5'h01;
		else
			step_pos = (p == wiper_host_pkg::POS_LOW) ? p : p - 5'h01;
	endfunction

	phase_timer u_timer (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.start_in   (t_start),
		.tick_out   (t_tick)
	);

	assign t_start = (state_q == ST_IDLE) ? (cmd_valid_in & cmd_ready_out)
		: t_tick && (state_q != ST_FINISH);

	// Sequencer
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q       <= ST_IDLE;
			cmd_q         <= '0;
			left_q        <= 5'h00;
			cmd_ready_out <= 1'b0;
			done_out      <= 1'b0;
		end else begin
			done_out <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					cmd_ready_out <= 1'b1;
					if (cmd_valid_in && cmd_ready_out) begin
						cmd_q         <= cmd_in;
						left_q        <= cmd_in.count;
						cmd_ready_out <= 1'b0;
						state_q       <= ST_SETUP;
					end
				end
				ST_SETUP: if (t_tick) begin
					if (cmd_q.kind == wiper_host_pkg::CMD_STEP &&
						left_q != 5'h00)
						state_q <= ST_FALL;
					else if (cmd_q.kind == wiper_host_pkg::CMD_ABANDON)
						state_q <= ST_FALL;
					else
						state_q <= ST_DESEL;
				end
				ST_FALL: if (t_tick) begin
					if (cmd_q.kind == wiper_host_pkg::CMD_ABANDON)
						state_q <= ST_DESEL;
					else
						state_q <= ST_RISE;
				end
				ST_RISE: if (t_tick) begin
					left_q <= left_q - 5'h01;
					if (left_q == 5'h01)
						state_q <= ST_DESEL;
					else
						state_q <= ST_FALL;
				end
				ST_DESEL: if (t_tick)
					state_q <= ST_FINISH;
				ST_FINISH: begin
					done_out <= 1'b1;
					state_q  <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Pin drive
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pins_out <= '{sel_n: 1'b1, dir_up: 1'b0, step_n: 1'b1};
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					pins_out.sel_n  <= 1'b1;
					pins_out.step_n <= 1'b1;
				end
				ST_SETUP: begin
					pins_out.dir_up <= cmd_q.up;
					if (t_tick && cmd_q.kind != wiper_host_pkg::CMD_ABANDON)
						pins_out.sel_n <= 1'b0;
					if (t_tick && cmd_q.kind == wiper_host_pkg::CMD_ABANDON)
						pins_out.sel_n <= 1'b0;
				end
				ST_FALL: if (t_tick) begin
					pins_out.step_n <= 1'b0;
				end
				ST_RISE: if (t_tick) begin
					pins_out.step_n <= 1'b1;
				end
				ST_DESEL: if (t_tick) begin
					pins_out.sel_n <= 1'b1;
				end
				ST_FINISH: pins_out.step_n <= 1'b1;
				default: pins_out <= pins_out;
			endcase
		end
	end

	// Shadow of device counter and stored value
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			live_pos_out   <= wiper_host_pkg::POS_RESET;
			stored_pos_out <= wiper_host_pkg::POS_RESET;
		end else if (recall_load_in) begin
			live_pos_out   <= recall_pos_in;
			stored_pos_out <= recall_pos_in;
		end else begin
			// Every falling step with select low moves the device, except at the end tap it is stepping toward
			if (state_q == ST_FALL && t_tick)
				live_pos_out <= step_pos(live_pos_out, cmd_q.up);
			if (state_q == ST_DESEL && t_tick && pins_out.step_n)
				stored_pos_out <= live_pos_out;
		end
	end

	a_sel_idle_high: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_q == ST_IDLE && $past(state_q) == ST_IDLE) |-> pins_out.sel_n)
		else $error("select low while idle");
	a_step_only_sel: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(pins_out.step_n) |-> !pins_out.sel_n)
		else $error("step fell with device deselected");
	a_dir_stable: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(pins_out.step_n) |-> $stable(pins_out.dir_up))
		else $error("direction changed at step edge");
	a_sat_high: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		($past(live_pos_out) == 5'h1F && !recall_load_in &&
		!$past(recall_load_in)) |-> live_pos_out != 5'h00)
		else $error("counter wrapped at high end");
	a_sat_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		($past(live_pos_out) == 5'h00 && !$past(recall_load_in))
		|-> live_pos_out != 5'h1F)
		else $error("counter wrapped at low end");
	a_store_edge: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		($rose(pins_out.sel_n) && pins_out.step_n && !$past(recall_load_in))
		|-> stored_pos_out == $past(live_pos_out))
		else $error("store missed on select rise");
	a_no_store_low: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		($rose(pins_out.sel_n) && !pins_out.step_n && !$past(recall_load_in))
		|-> $stable(stored_pos_out))
		else $error("store taken with step low");
	a_step_no_store: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		($fell(pins_out.step_n) && !$past(recall_load_in))
		|-> $stable(stored_pos_out))
		else $error("stored value moved on step");
	a_recall_load: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		recall_load_in |=> live_pos_out == $past(recall_pos_in))
		else $error("recall not loaded");
	a_done_bound: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_q == ST_DESEL && t_tick) |-> ##1 state_q == ST_FINISH ##1 done_out)
		else $error("done not pulsed");

	c_step_up: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(pins_out.step_n) && pins_out.dir_up);
	c_step_down: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(pins_out.step_n) && !pins_out.dir_up);
	c_store: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(pins_out.sel_n) && pins_out.step_n);
	c_abandon: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(pins_out.sel_n) && !pins_out.step_n);
endmodule // wiper_host
`default_nettype wire

// >>> logic/wiper_host_pkg.sv
// Constants and carrier types for the wiper position host controller
// Assumes a 100 MHz reference clock and a three-pin up/down pot device
package wiper_host_pkg;
	localparam int unsigned POS_W        = 5;
	localparam int unsigned TAP_COUNT    = 32;
	localparam logic [4:0]  POS_LOW      = 5'h00;
	localparam logic [4:0]  POS_HIGH     = 5'h1F;
	localparam logic [4:0]  POS_RESET    = 5'h00;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned PHASE_NS     = 100;
	localparam int unsigned PHASE_CYC    =
		(PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W        = 8;

	typedef enum logic [1:0] {
		CMD_STEP    = 2'h0,
		CMD_STORE   = 2'h1,
		CMD_ABANDON = 2'h2
	} cmd_kind_t;

	typedef struct packed {
		cmd_kind_t  kind;
		logic       up;
		logic [4:0] count;
	} cmd_t;

	typedef struct packed {
		logic sel_n;
		logic dir_up;
		logic step_n;
	} pins_t;
endpackage : wiper_host_pkg

// >>> testbench/pot_device_model.sv
// Behavioural model of the three-pin up/down potentiometer
// Assumes pins come straight from host registers; no clock
`timescale 1ns/1ps
`default_nettype none
module pot_device_model #(
	parameter logic [4:0] NV_INIT = 5'h0A
) (
	input  wire logic  sel_n_in,
	input  wire logic  dir_up_in,
	input  wire logic  step_n_in,
	output logic [4:0] pos_out,
	output logic [4:0] nv_out
);
	// Stored value kept across power-down, recalled at power-up
	initial begin
		nv_out = NV_INIT;
		pos_out = NV_INIT;
	end

	// Five-bit counter, zero at low terminal, saturating both ends
	always @(negedge step_n_in) begin
		if (sel_n_in === 1'b0) begin
			if (dir_up_in === 1'b1 && pos_out != 5'h1F)
				pos_out = pos_out + 5'h01;
			else if (dir_up_in === 1'b0 && pos_out != 5'h00)
				pos_out = pos_out - 5'h01;
		end
	end

	// Select rising: store only while step is high
	always @(posedge sel_n_in) begin
		if (step_n_in === 1'b1)
			nv_out = pos_out;
	end
endmodule // pot_device_model
`default_nettype wire

// >>> testbench/test_wiper_host.sv
// Self-checking bench for the wiper host controller
// Assumes the device model recalls its stored value at time zero
`timescale 1ns/1ps
`default_nettype none
module test_wiper_host;
	logic                  ref_clk_in;
	logic                  rst_in;
	logic                  cmd_valid_in;
	logic                  recall_load_in;
	wiper_host_pkg::cmd_t  cmd_in;
	wiper_host_pkg::pins_t pins_out;
	logic                  cmd_ready_out;
	logic                  done_out;
	logic [4:0]            live_pos_out;
	logic [4:0]            stored_pos_out;
	logic [4:0]            dev_pos;
	logic [4:0]            dev_nv;
	logic [4:0]            exp_live;
	logic [4:0]            exp_stored;
	logic                  exp_dir;
	int                    miscompares;
	int                    num_checks;

	wiper_host uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
		.recall_pos_in(dev_nv), .recall_load_in(recall_load_in),
		.cmd_ready_out(cmd_ready_out), .pins_out(pins_out),
		.live_pos_out(live_pos_out), .stored_pos_out(stored_pos_out),
		.done_out(done_out));
	pot_device_model #(.NV_INIT(5'h0A)) dev (.sel_n_in(pins_out.sel_n),
		.dir_up_in(pins_out.dir_up), .step_n_in(pins_out.step_n),
		.pos_out(dev_pos), .nv_out(dev_nv));

	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	task automatic check(input string name, input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_state();
		check("live", {3'h0, live_pos_out}, {3'h0, exp_live});
		check("device pos", {3'h0, dev_pos}, {3'h0, exp_live});
		check("stored", {3'h0, stored_pos_out}, {3'h0, exp_stored});
		check("device nv", {3'h0, dev_nv}, {3'h0, exp_stored});
		check("idle pins", {5'h00, pins_out},
			{5'h00, 1'b1, exp_dir, 1'b1});
	endtask

	task automatic do_cmd(input wiper_host_pkg::cmd_kind_t k,
			input logic up, input logic [4:0] n);
		int i;
		cmd_in = '{kind: k, up: up, count: n};
		cmd_valid_in = 1'b1;
		exp_dir = up;
		i = 0;
		while (cmd_ready_out !== 1'b1 && i < 100) begin
			@(posedge ref_clk_in);
			#1 i++;
		end
		@(posedge ref_clk_in);
		#1 cmd_valid_in = 1'b0;
		i = 0;
		while (done_out !== 1'b1 && i < 2000) begin
			@(posedge ref_clk_in);
			#1 i++;
		end
		if (i >= 2000) begin
			miscompares++;
			results();
		end
		@(posedge ref_clk_in);
		#1;
	endtask

	task automatic run_step(input logic up, input logic [4:0] n);
		do_cmd(wiper_host_pkg::CMD_STEP, up, n);
		for (int i = 0; i < n; i++) begin
			if (up && exp_live != 5'h1F)
				exp_live = exp_live + 5'h01;
			else if (!up && exp_live != 5'h00)
				exp_live = exp_live - 5'h01;
		end
		exp_stored = exp_live;
		check_state();
	endtask

	task automatic t_recall();
		recall_load_in = 1'b1;
		@(posedge ref_clk_in);
		#1 recall_load_in = 1'b0;
		exp_live = 5'h0A;
		exp_stored = 5'h0A;
		@(posedge ref_clk_in);
		#1 check_state();
	endtask

	task automatic t_abandon();
		do_cmd(wiper_host_pkg::CMD_ABANDON, 1'b1, 5'h00);
		exp_live = exp_live + 5'h01;
		check_state();
		do_cmd(wiper_host_pkg::CMD_STORE, 1'b0, 5'h00);
		exp_stored = exp_live;
		check_state();
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		results();
	end

	initial begin
		miscompares = 0;
		num_checks = 0;
		rst_in = 1'b1;
		cmd_valid_in = 1'b0;
		recall_load_in = 1'b0;
		exp_dir = 1'b0;
		cmd_in = '0;
		repeat (8) @(posedge ref_clk_in);
		#1 check("reset pins", {5'h00, pins_out}, 8'h05);
		rst_in = 1'b0;
		repeat (2) @(posedge ref_clk_in);
		#1 t_recall();
		run_step(1'b1, 5'h03);
		run_step(1'b1, 5'h1F);
		run_step(1'b0, 5'h02);
		run_step(1'b0, 5'h1F);
		run_step(1'b1, 5'h00);
		t_abandon();
		results();
	end
endmodule // test_wiper_host
`default_nettype wire
